// *** pmove_pkg.sv ***
// Package with opcode fields, register codes and timing constants for the parallel move decoder.
`default_nettype none
package pmove_pkg;
	localparam int WORD_W = 24;
	localparam int ADDR_W = 16;
	localparam int EXT_W = 8;
	localparam int ACC_W = 56;
	localparam logic [23:0] SAT_POS = 24'h7FFFFF;
	localparam logic [23:0] SAT_NEG = 24'h800000;
	localparam logic [23:0] ZERO_WORD = 24'h000000;
	localparam logic [15:0] ZERO_ADDR = 16'h0000;
	localparam logic [7:0] ZERO_EXT = 8'h00;
	localparam logic [7:0] ONES_EXT = 8'hFF;
	// Opcode pattern for the pointer-update-only form: bits 23..13.
	localparam logic [10:0] UPD_PATTERN = 11'h102;
	// Upper patterns for the X move forms.
	localparam logic [1:0] XMOVE_TOP = 2'h1;
	localparam logic [3:0] XR1_TOP = 4'h1;
	localparam logic [6:0] XR2_TOP = 7'h04;
	// Long effective address codes.
	localparam logic [5:0] EA_ABS = 6'h30;
	localparam logic [5:0] EA_IMM = 6'h34;
	// Mode field values.
	localparam logic [2:0] MODE_MINUS_N = 3'h0;
	localparam logic [2:0] MODE_PLUS_N = 3'h1;
	localparam logic [2:0] MODE_POSTDEC = 3'h2;
	localparam logic [2:0] MODE_POSTINC = 3'h3;
	localparam logic [2:0] MODE_PLAIN = 3'h4;
	localparam logic [2:0] MODE_INDEX = 3'h5;
	localparam logic [2:0] MODE_LONG = 3'h6;
	localparam logic [2:0] MODE_PREDEC = 3'h7;
	// Register code fields.
	localparam logic [1:0] RC_PTR = 2'h2;
	localparam logic [1:0] RC_OFS = 2'h3;
	localparam logic [4:0] RC_X0 = 5'h04;
	localparam logic [4:0] RC_X1 = 5'h05;
	localparam logic [4:0] RC_Y0 = 5'h06;
	localparam logic [4:0] RC_Y1 = 5'h07;
	localparam logic [4:0] RC_A0 = 5'h08;
	localparam logic [4:0] RC_B0 = 5'h09;
	localparam logic [4:0] RC_A2 = 5'h0A;
	localparam logic [4:0] RC_B2 = 5'h0B;
	localparam logic [4:0] RC_A1 = 5'h0C;
	localparam logic [4:0] RC_B1 = 5'h0D;
	localparam logic [4:0] RC_A = 5'h0E;
	localparam logic [4:0] RC_B = 5'h0F;
	// Pipeline delay before a written pointer becomes usable, in instructions.
	localparam int PTR_DELAY = 1;
	typedef enum logic [1:0] {
		ST_DECODE = 2'b00,
		ST_EXT = 2'b01,
		ST_MEM = 2'b10
	} state_e;
endpackage : pmove_pkg
`default_nettype wire

// *** acc_limiter.sv ***
// Accumulator limiter that yields the word stored from a whole accumulator.
`timescale 1ns/1ps
`default_nettype none
module acc_limiter
	import pmove_pkg::*;
(
	input wire logic [55:0] acc, // whole accumulator
	output logic [23:0] word, // limited middle word
	output logic limited // limiting took place
);
	logic in_use;
	// Extension in use when bits 55..47 are not all equal.
	assign in_use = !((acc[55:47] == 9'h000) || (acc[55:47] == 9'h1FF));
	assign limited = in_use;
	assign word = !in_use ? acc[47:24] : (acc[55] ? SAT_NEG : SAT_POS);
endmodule : acc_limiter
`default_nettype wire

// *** parallel_move_decoder.sv ***
// Decoder and executor for the pointer update, X memory and X-register parallel moves.
// Behaviour
// - Pointer-update form: mode and pointer field.
// - X move reads or writes one word.
// - Long address or immediate from extension word; the decoder takes the immediate from mem_rdata one cycle later instead.
// - Short absolute X move with direction bit.
// - All addressing modes accepted for X move; mode 6 only with the absolute or immediate code.
// - Five-bit register codes select register groups.
// - Duplicate sources read the same old value.
// - Wide into pointer keeps low 16 bits.
// - Narrow into wide zeroes upper byte.
// - Written pointer usable one instruction later.
// - Accumulator store writes saturation constant when limiting.
// - Limiting flag set, no other flags.
// - Pre-decrement stores the new pointer value.
// - Class one: X move plus accumulator copy.
// - Copied input register ready next instruction.
// - Class two: store accumulator, load from first input.
// - Same source gives same limited value twice.
// - Word into accumulator sign-extends, clears low.
`timescale 1ns/1ps
`default_nettype none
module parallel_move_decoder
	import pmove_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic instr_valid, // fetch offers a word
	input wire logic [23:0] instr_word, // opcode or extension word
	output logic instr_ready, // word taken at the preceding rising edge
	output logic [15:0] mem_addr, // X memory address
	output logic mem_rd, // X memory read strobe
	output logic mem_wr, // X memory write strobe
	output logic [23:0] mem_wdata, // X memory write data
	input wire logic [23:0] mem_rdata, // X memory read data, sampled in the same cycle as the read strobe
	output logic limit_flag, // sticky limiting status bit
	input wire logic limit_clear, // clears limiting flag
	output logic illegal, // pulse for an unknown opcode
	output logic done, // pulse when a move completes
	output logic [23:0] first_input_word, // input register contents
	output logic [23:0] second_input_word, // input register contents
	output logic [23:0] third_input_word, // input register contents
	output logic [23:0] fourth_input_word, // input register contents
	output logic [55:0] acc_a, // first accumulator
	output logic [55:0] acc_b, // second accumulator
	output logic [127:0] ptr_visible // eight pointers, one cycle behind the registers used by address arithmetic
);
	localparam int NPTR = 8;
	state_e st_q, st_d;
	logic [15:0] address_pointers_q [NPTR], address_pointers_d [NPTR];
	logic [15:0] offset_registers_q [NPTR], offset_registers_d [NPTR];
	logic [15:0] ptr_vis_q [NPTR], ptr_vis_d [NPTR];
	logic [23:0] x0_q, x0_d, x1_q, x1_d, y0_q, y0_d, y1_q, y1_d;
	logic [55:0] a_q, a_d, b_q, b_d;
	logic [23:0] op_q, op_d;
	logic [4:0] rd_reg_q, rd_reg_d;
	logic rd_pend_q, rd_pend_d;
	logic [15:0] maddr_q, maddr_d;
	logic mrd_q, mrd_d, mwr_q, mwr_d;
	logic [23:0] wdat_q, wdat_d;
	logic lim_q, lim_d, ill_q, ill_d, done_q, done_d, rdy_q, rdy_d;
	logic [23:0] lim_a_w, lim_b_w;
	logic lim_a, lim_b;

	acc_limiter u_lim_a (.acc(a_q), .word(lim_a_w), .limited(lim_a));
	acc_limiter u_lim_b (.acc(b_q), .word(lim_b_w), .limited(lim_b));

	function automatic logic [23:0] read_reg(input logic [4:0] c, input logic [23:0] x0, input logic [23:0] x1,
		input logic [23:0] y0, input logic [23:0] y1, input logic [55:0] a, input logic [55:0] b,
		input logic [23:0] la, input logic [23:0] lb, input logic [15:0] p, input logic [15:0] n);
		logic [23:0] r;
		r = ZERO_WORD;
		if (c[4:3] == RC_PTR) r = {ZERO_EXT, p};
		else if (c[4:3] == RC_OFS) r = {ZERO_EXT, n};
		else case (c)
			RC_X0: r = x0;
			RC_X1: r = x1;
			RC_Y0: r = y0;
			RC_Y1: r = y1;
			RC_A0: r = a[23:0];
			RC_B0: r = b[23:0];
			RC_A2: r = {{16{a[55]}}, a[55:48]};
			RC_B2: r = {{16{b[55]}}, b[55:48]};
			RC_A1: r = a[47:24];
			RC_B1: r = b[47:24];
			RC_A: r = la;
			RC_B: r = lb;
			default: r = ZERO_WORD;
		endcase
		return r;
	endfunction : read_reg

	function automatic logic reg_legal(input logic [4:0] c);
		return (c[4] == 1'b1) || (c >= RC_X0 && c <= RC_B);
	endfunction : reg_legal

	always_comb begin
		logic [4:0] rc;
		logic [2:0] mode;
		logic [2:0] rn;
		logic [15:0] p, n, eff, upd;
		logic wr_dir, src_lim, ok;
		logic [23:0] sval;
		rc = ZERO_EXT[4:0];
		mode = 3'h0;
		rn = 3'h0;
		p = ZERO_ADDR;
		n = ZERO_ADDR;
		eff = ZERO_ADDR;
		upd = ZERO_ADDR;
		wr_dir = 1'b0;
		src_lim = 1'b0;
		ok = 1'b0;
		sval = ZERO_WORD;
		st_d = st_q;
		op_d = op_q;
		rd_reg_d = rd_reg_q;
		rd_pend_d = 1'b0;
		maddr_d = maddr_q;
		mrd_d = 1'b0;
		mwr_d = 1'b0;
		wdat_d = wdat_q;
		lim_d = lim_q & ~limit_clear;
		ill_d = 1'b0;
		done_d = 1'b0;
		rdy_d = 1'b0;
		x0_d = x0_q;
		x1_d = x1_q;
		y0_d = y0_q;
		y1_d = y1_q;
		a_d = a_q;
		b_d = b_q;
		for (int i = 0; i < NPTR; i++) begin
			address_pointers_d[i] = address_pointers_q[i];
			offset_registers_d[i] = offset_registers_q[i];
			ptr_vis_d[i] = address_pointers_q[i];
		end
		// Memory read data present in this read strobe cycle lands in its destination now.
		if (rd_pend_q) begin
			sval = mem_rdata;
			done_d = 1'b1;
			if (rd_reg_q[4:3] == RC_PTR) address_pointers_d[rd_reg_q[2:0]] = sval[15:0];
			else if (rd_reg_q[4:3] == RC_OFS) offset_registers_d[rd_reg_q[2:0]] = sval[15:0];
			else case (rd_reg_q)
				RC_X0: x0_d = sval;
				RC_X1: x1_d = sval;
				RC_Y0: y0_d = sval;
				RC_Y1: y1_d = sval;
				RC_A0: a_d[23:0] = sval;
				RC_B0: b_d[23:0] = sval;
				RC_A2: a_d[55:48] = sval[7:0];
				RC_B2: b_d[55:48] = sval[7:0];
				RC_A1: a_d[47:24] = sval;
				RC_B1: b_d[47:24] = sval;
				RC_A: a_d = {{8{sval[23]}}, sval, ZERO_WORD};
				RC_B: b_d = {{8{sval[23]}}, sval, ZERO_WORD};
				default: ;
			endcase
		end
		case (st_q)
			ST_DECODE: begin
				if (instr_valid && !rd_pend_q) begin
					rdy_d = 1'b1;
					op_d = instr_word;
					mode = instr_word[13:11];
					rn = instr_word[10:8];
					p = address_pointers_q[rn];
					n = offset_registers_q[rn];
					// Reads take the old register values before any update; a predecremented source pointer is the exception.
					case (mode)
						MODE_MINUS_N: begin eff = p; upd = p - n; end
						MODE_PLUS_N: begin eff = p; upd = p + n; end
						MODE_POSTDEC: begin eff = p; upd = p - 16'h0001; end
						MODE_POSTINC: begin eff = p; upd = p + 16'h0001; end
						MODE_INDEX: begin eff = p + n; upd = p; end
						MODE_PREDEC: begin eff = p - 16'h0001; upd = eff; end
						default: begin eff = p; upd = p; end
					endcase
					wr_dir = instr_word[15];
					rc = {instr_word[21:20], instr_word[18:16]};
					if (instr_word[23:13] == UPD_PATTERN) begin
						// Pointer-update form uses a two-bit mode.
						case (instr_word[12:11])
							2'h0: address_pointers_d[instr_word[10:8]] = p - n;
							2'h1: address_pointers_d[instr_word[10:8]] = p + n;
							2'h2: address_pointers_d[instr_word[10:8]] = p - 16'h0001;
							default: address_pointers_d[instr_word[10:8]] = p + 16'h0001;
						endcase
						done_d = 1'b1;
					end else if (instr_word[23:22] == XMOVE_TOP && instr_word[19] == 1'b0) begin
						ok = reg_legal(rc);
						if (!ok) ill_d = 1'b1;
						else begin
							rd_reg_d = rc;
							if (instr_word[14] == 1'b0) begin
								maddr_d = {10'h000, instr_word[13:8]};
								st_d = ST_MEM;
							end else if (instr_word[13:8] == EA_ABS || instr_word[13:8] == EA_IMM) begin
								st_d = ST_EXT;
							end else if (mode == MODE_LONG) begin
								ill_d = 1'b1;
							end else begin
								maddr_d = eff;
								address_pointers_d[rn] = upd;
								st_d = ST_MEM;
							end
							if (ok && !wr_dir && st_d == ST_MEM) begin
								// Source pointer equal to addressing pointer sees the predecrement.
								if (rc == {RC_PTR, rn} && mode == MODE_PREDEC && instr_word[14]) wdat_d = {ZERO_EXT, eff};
								else wdat_d = read_reg(rc, x0_q, x1_q, y0_q, y1_q, a_q, b_q, lim_a_w, lim_b_w,
									address_pointers_q[rc[2:0]], offset_registers_q[rc[2:0]]);
								src_lim = (rc == RC_A && lim_a) || (rc == RC_B && lim_b);
							end
						end
					end else if (instr_word[23:20] == XR1_TOP || instr_word[23:17] == XR2_TOP) begin
						if (instr_word[14] || mode == MODE_LONG) ill_d = 1'b1;
						else begin
							maddr_d = eff;
							address_pointers_d[rn] = upd;
							st_d = ST_MEM;
							if (instr_word[23:20] == XR1_TOP) begin
								// Class one: accumulator into third or fourth input word.
								sval = instr_word[17] ? lim_b_w : lim_a_w;
								src_lim = instr_word[17] ? lim_b : lim_a;
								if (instr_word[16]) y1_d = sval;
								else y0_d = sval;
								rd_reg_d = instr_word[19] ? (instr_word[18] ? RC_B : RC_A) : (instr_word[18] ? RC_X1 : RC_X0);
								if (!wr_dir) begin
									wdat_d = read_reg(rd_reg_d, x0_q, x1_q, y0_q, y1_q, a_q, b_q, lim_a_w, lim_b_w,
										ZERO_ADDR, ZERO_ADDR);
									src_lim = src_lim | (rd_reg_d == RC_A && lim_a) | (rd_reg_d == RC_B && lim_b);
								end
							end else begin
								// Class two: store accumulator, reload it from the first input word.
								wr_dir = 1'b0;
								wdat_d = instr_word[16] ? lim_b_w : lim_a_w;
								src_lim = instr_word[16] ? lim_b : lim_a;
								if (instr_word[16]) b_d = {{8{x0_q[23]}}, x0_q, ZERO_WORD};
								else a_d = {{8{x0_q[23]}}, x0_q, ZERO_WORD};
							end
						end
					end else begin
						ill_d = 1'b1;
					end
					if (src_lim) lim_d = 1'b1;
					op_d[15] = wr_dir;
				end
			end
			ST_EXT: begin
				if (instr_valid) begin
					rdy_d = 1'b1;
					if (op_q[13:8] == EA_IMM) begin
						rd_pend_d = 1'b1; // immediate behaves as a read that lands next cycle
						st_d = ST_DECODE;
					end else begin
						maddr_d = instr_word[15:0];
						st_d = ST_MEM;
						if (!op_q[15]) begin
							wdat_d = read_reg(rd_reg_q, x0_q, x1_q, y0_q, y1_q, a_q, b_q, lim_a_w, lim_b_w,
								address_pointers_q[rd_reg_q[2:0]], offset_registers_q[rd_reg_q[2:0]]);
							if ((rd_reg_q == RC_A && lim_a) || (rd_reg_q == RC_B && lim_b)) lim_d = 1'b1;
						end
					end
				end
			end
			ST_MEM: begin
				// One memory access in the direction set by the opcode.
				if (op_q[15]) begin
					mrd_d = 1'b1;
					rd_pend_d = 1'b1;
				end else begin
					mwr_d = 1'b1;
					done_d = 1'b1;
				end
				st_d = ST_DECODE;
			end
			default: st_d = ST_DECODE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_DECODE;
			for (int i = 0; i < NPTR; i++) begin
				address_pointers_q[i] <= ZERO_ADDR;
				offset_registers_q[i] <= ZERO_ADDR;
				ptr_vis_q[i] <= ZERO_ADDR;
			end
			{x0_q, x1_q, y0_q, y1_q} <= {4{ZERO_WORD}};
			a_q <= {ZERO_EXT, ZERO_WORD, ZERO_WORD};
			b_q <= {ZERO_EXT, ZERO_WORD, ZERO_WORD};
			op_q <= ZERO_WORD;
			rd_reg_q <= RC_X0;
			rd_pend_q <= 1'b0;
			maddr_q <= ZERO_ADDR;
			mrd_q <= 1'b0;
			mwr_q <= 1'b0;
			wdat_q <= ZERO_WORD;
			lim_q <= 1'b0;
			ill_q <= 1'b0;
			done_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			address_pointers_q <= address_pointers_d;
			offset_registers_q <= offset_registers_d;
			ptr_vis_q <= ptr_vis_d;
			x0_q <= x0_d;
			x1_q <= x1_d;
			y0_q <= y0_d;
			y1_q <= y1_d;
			a_q <= a_d;
			b_q <= b_d;
			op_q <= op_d;
			rd_reg_q <= rd_reg_d;
			rd_pend_q <= rd_pend_d;
			maddr_q <= maddr_d;
			mrd_q <= mrd_d;
			mwr_q <= mwr_d;
			wdat_q <= wdat_d;
			lim_q <= lim_d;
			ill_q <= ill_d;
			done_q <= done_d;
			rdy_q <= rdy_d;
		end
	end

	assign instr_ready = rdy_q;
	assign mem_addr = maddr_q;
	assign mem_rd = mrd_q;
	assign mem_wr = mwr_q;
	assign mem_wdata = wdat_q;
	assign limit_flag = lim_q;
	assign illegal = ill_q;
	assign done = done_q;
	assign first_input_word = x0_q;
	assign second_input_word = x1_q;
	assign third_input_word = y0_q;
	assign fourth_input_word = y1_q;
	assign acc_a = a_q;
	assign acc_b = b_q;
	for (genvar g = 0; g < NPTR; g++) begin : g_vis
		assign ptr_visible[g*16 +: 16] = ptr_vis_q[g];
	end

	no_wr_illegal_a: assert property (@(posedge clk) disable iff (rst) ill_q |-> !mwr_q)
		else $error("memory write alongside illegal opcode");
	rd_wr_excl_a: assert property (@(posedge clk) disable iff (rst) !(mrd_q && mwr_q))
		else $error("read and write strobes together");
	read_done_a: assert property (@(posedge clk) disable iff (rst) mrd_q |=> done_q)
		else $error("read did not complete one cycle later");
	lim_sticky_a: assert property (@(posedge clk) disable iff (rst) lim_q && !limit_clear |=> lim_q)
		else $error("limiting flag dropped without clear");
	sat_value_a: assert property (@(posedge clk) disable iff (rst)
		mwr_q && lim_q && !$past(lim_q, 2) && ((op_q[23:22] == XMOVE_TOP && (rd_reg_q == RC_A || rd_reg_q == RC_B))
		|| op_q[23:17] == XR2_TOP) |-> (wdat_q == SAT_POS || wdat_q == SAT_NEG))
		else $error("limited store not a saturation constant");
	ptr_lag_a: assert property (@(posedge clk) disable iff (rst) ##1 ptr_vis_q[0] == $past(address_pointers_q[0]))
		else $error("pointer visible without one-cycle delay");
	mem_follows_a: assert property (@(posedge clk) disable iff (rst) st_q == ST_MEM |=> (mrd_q || mwr_q))
		else $error("memory phase produced no access");
	class2_load_a: assert property (@(posedge clk) disable iff (rst)
		rdy_q && st_q == ST_MEM && op_q[23:17] == XR2_TOP
		|-> (op_q[16] ? b_q[47:24] : a_q[47:24]) == $past(x0_q))
		else $error("class two did not load accumulator from first input");
	cov_update_c: cover property (@(posedge clk) done_q && !mrd_q && !mwr_q);
	cov_write_c: cover property (@(posedge clk) mwr_q && lim_q);
	cov_read_c: cover property (@(posedge clk) mrd_q ##1 done_q);
	cov_illegal_c: cover property (@(posedge clk) ill_q);
endmodule : parallel_move_decoder
`default_nettype wire

// *** xmem_model.sv ***
// X data memory model that answers the decoder's reads and keeps its writes.
`timescale 1ns/1ps
`default_nettype none
module xmem_model (
	input wire logic clk, // core clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic [15:0] mem_addr, // word address
	input wire logic mem_rd, // read strobe
	input wire logic mem_wr, // write strobe
	input wire logic [23:0] mem_wdata, // write data
	input wire logic imm_en, // present an immediate operand instead of memory
	input wire logic [23:0] imm_val, // immediate operand
	output logic [23:0] mem_rdata // read data
);
	logic [23:0] mem [0:65535];
	logic [23:0] hold_q;
	logic [23:0] junk_q;
	logic rd_q;
	// Outside a read the bus holds the read word for one cycle, then toggles every cycle, so a later sample never matches real data.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q <= 1'b0;
			junk_q <= 24'h5A5A5A;
			hold_q <= 24'h000000;
		end else begin
			rd_q <= mem_rd;
			junk_q <= ~junk_q;
			if (mem_rd)
				hold_q <= mem[mem_addr];
			if (mem_wr)
				mem[mem_addr] <= mem_wdata;
		end
	end
	always_comb begin
		if (imm_en)
			mem_rdata = imm_val;
		else if (mem_rd)
			mem_rdata = mem[mem_addr];
		else if (rd_q)
			mem_rdata = hold_q;
		else
			mem_rdata = junk_q;
	end
endmodule : xmem_model
`default_nettype wire

// *** parallel_move_decoder_tb_top.sv ***
// Self-checking testbench for the parallel move decoder.
`timescale 1ns/1ps
`default_nettype none
module parallel_move_decoder_tb_top;
	import pmove_pkg::*;
	logic clk = 0, rst = 1, instr_valid = 0, limit_clear = 0, imm_en = 0;
	logic [23:0] instr_word = 0, imm_val = 0, mem_rdata, mem_wdata, wd;
	logic [23:0] first_input_word, second_input_word, third_input_word, fourth_input_word;
	logic [15:0] mem_addr, wa;
	logic instr_ready, mem_rd, mem_wr, limit_flag, illegal, done;
	logic [55:0] acc_a, acc_b;
	logic [127:0] ptr_visible;
	int n_fail = 0, checks = 0, ev_n = 0, wr_n = 0, ill_n = 0, rdy_n = 0, rd_n = 0;
	always #50 clk = ~clk;
	parallel_move_decoder u_dut (.clk, .rst, .instr_valid, .instr_word, .instr_ready, .mem_addr, .mem_rd,
		.mem_wr, .mem_wdata, .mem_rdata, .limit_flag, .limit_clear, .illegal, .done, .first_input_word,
		.second_input_word, .third_input_word, .fourth_input_word, .acc_a, .acc_b, .ptr_visible);
	xmem_model u_mem (.clk, .rst, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .imm_en, .imm_val, .mem_rdata);
	always @(posedge clk) if (!rst) begin
		if (done === 1'b1 || illegal === 1'b1) ev_n++;
		if (illegal === 1'b1) ill_n++;
		if (instr_ready === 1'b1) rdy_n++;
		if (mem_rd === 1'b1) rd_n++;
		if (mem_wr === 1'b1) begin
			wr_n++;
			wa = mem_addr;
			wd = mem_wdata;
		end
	end
	function automatic logic [55:0] sx(input logic [23:0] v);
		return {{8{v[23]}}, v, 24'h000000};
	endfunction : sx
	function automatic logic [15:0] ptr(input int i);
		return ptr_visible[16*i +: 16];
	endfunction : ptr
	function automatic logic [23:0] xop(input logic w, input logic [4:0] c, input logic [6:0] m);
		return {2'b01, c[4:3], 1'b0, c[2:0], w, m, 8'h00};
	endfunction : xop
	function automatic logic [23:0] inreg(input logic [4:0] c);
		case (c)
			5'h04: return first_input_word;
			5'h05: return second_input_word;
			5'h06: return third_input_word;
			default: return fourth_input_word;
		endcase
	endfunction : inreg
	task automatic print_verdict();
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [55:0] got, input logic [55:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// A word is taken at the first rising edge in decode or extension state, so the
	// extension word replaces the opcode at the falling edge that follows it.
	task automatic run(input logic [23:0] op, input logic [23:0] ext, input bit has_ext);
		int e, r, n;
		e = ev_n;
		r = rdy_n;
		n = 0;
		@(negedge clk);
		instr_valid = 1;
		instr_word = op;
		@(negedge clk);
		if (has_ext) begin
			instr_word = ext;
			@(negedge clk);
		end
		instr_valid = 0;
		while (ev_n == e && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n == 40)
			chk("completion", 1, 0);
		repeat (2) @(negedge clk);
		chk("words taken", rdy_n - r, has_ext ? 2 : 1);
	endtask : run
	task automatic ld(input logic [4:0] c, input logic [23:0] v);
		logic [5:0] a;
		int r;
		a = 6'($urandom);
		r = rd_n;
		u_mem.mem[{10'h000, a}] = v;
		run(xop(1, c, {1'b0, a}), 0, 0);
		chk("read count", rd_n, r + 1);
	endtask : ld
	task automatic st(input logic [4:0] c);
		logic [5:0] a;
		int w;
		a = 6'($urandom);
		w = wr_n;
		run(xop(0, c, {1'b0, a}), 0, 0);
		chk("write count", wr_n, w + 1);
		chk("write address", wa, {10'h000, a});
	endtask : st
	task automatic clr();
		@(negedge clk) limit_clear = 1;
		@(negedge clk) limit_clear = 0;
		chk("flag cleared", limit_flag, 0);
	endtask : clr
	initial begin
		#(100 * 4000);
		n_fail++;
		print_verdict();
	end
	initial begin
		logic [23:0] v;
		logic [55:0] e56;
		logic [15:0] p, n, a16;
		logic [4:0] c;
		int w, e;
		void'($urandom(81));
		repeat (16) @(posedge clk);
		@(negedge clk) rst = 0;
		chk("flag after reset", limit_flag, 0);
		repeat (16) begin
			c = 5'h04 + 5'($urandom_range(3));
			v = $urandom;
			ld(c, v);
			chk("input word", inreg(c), v);
			st(c);
			chk("stored word", wd, v);
		end
		v = $urandom | 24'h800000;
		ld(5'h0E, v);
		e56 = sx(v);
		chk("accumulator a", acc_a, e56);
		v = $urandom & 24'h7FFFFF;
		ld(5'h0F, v);
		chk("accumulator b", acc_b, sx(v));
		ld(5'h08, 24'h123456);
		chk("low word", acc_a, {e56[55:24], 24'h123456});
		ld(5'h0E, 0);
		ld(5'h0C, 24'h800000);
		chk("flag before limiting", limit_flag, 0);
		st(5'h0E);
		chk("positive limit", wd, SAT_POS);
		chk("flag after limiting", limit_flag, 1);
		st(5'h0C);
		chk("raw middle word", wd, 24'h800000);
		clr();
		ld(5'h0E, 24'h800000);
		ld(5'h0C, 24'h7FFFFF);
		st(5'h0E);
		chk("negative limit", wd, SAT_NEG);
		clr();
		v = $urandom;
		ld(5'h0E, v);
		st(5'h0E);
		chk("unlimited store", wd, v);
		chk("flag stays clear", limit_flag, 0);
		ld(5'h13, 24'hABCDEF);
		chk("pointer low bits", ptr(3), 16'hCDEF);
		st(5'h13);
		chk("pointer widened", wd, 24'h00CDEF);
		n = 16'($urandom_range(255, 1));
		ld(5'h1B, {8'h00, n});
		p = 16'hCDEF;
		for (int m = 0; m < 4; m++) begin
			run({11'b00100000010, 2'(m), 3'd3, 8'h00}, 0, 0);
			p = (m == 0) ? p - n : (m == 1) ? p + n : (m == 2) ? p - 16'h0001 : p + 16'h0001;
			chk("pointer update", ptr(3), p);
		end
		v = $urandom;
		ld(5'h04, v);
		run(xop(0, 5'h04, {1'b1, 6'b011011}), 0, 0);
		chk("ea address", wa, p);
		chk("ea data", wd, v);
		p = p + 16'h0001;
		chk("ea post increment", ptr(3), p);
		run(xop(0, 5'h04, {1'b1, 6'b101011}), 0, 0);
		chk("indexed address", wa, 16'(p + n));
		chk("indexed keeps pointer", ptr(3), p);
		run(xop(0, 5'h04, {1'b1, 6'b000011}), 0, 0);
		chk("minus offset address", wa, p);
		p = p - n;
		chk("minus offset update", ptr(3), p);
		a16 = 16'($urandom);
		v = $urandom;
		u_mem.mem[a16] = v;
		run(xop(1, 5'h05, {1'b1, 6'b110000}), {8'h00, a16}, 1);
		chk("absolute read", second_input_word, v);
		imm_val = $urandom;
		imm_en = 1;
		run(xop(1, 5'h07, {1'b1, 6'b110100}), imm_val, 1);
		imm_en = 0;
		chk("immediate load", fourth_input_word, imm_val);
		ld(5'h12, 24'h001001);
		run(xop(0, 5'h12, {1'b1, 6'b111010}), 0, 0);
		chk("predecrement address", wa, 16'h1000);
		chk("predecrement data", wd, 24'h001000);
		w = wr_n;
		e = ill_n;
		run(xop(0, 5'h00, 7'h05), 0, 0);
		chk("illegal pulse", ill_n, e + 1);
		chk("no illegal write", wr_n, w);
		ld(5'h04, 24'h400000);
		ld(5'h0F, 24'h800000);
		ld(5'h0D, 24'h7FFFFF);
		clr();
		// Short effective address only, and no accumulator named twice as destination.
		run({8'h09, 2'b00, 6'b100011, 8'h00}, 0, 0);
		chk("class two store", wd, SAT_NEG);
		chk("class two address", wa, p);
		chk("class two load", acc_b, sx(24'h400000));
		chk("class two flag", limit_flag, 1);
		ld(5'h0E, 0);
		ld(5'h0C, 24'h800000);
		run({8'h18, 8'h23, 8'h00}, 0, 0);
		chk("class one store", wd, SAT_POS);
		chk("class one copy", third_input_word, SAT_POS);
		print_verdict();
	end
endmodule : parallel_move_decoder_tb_top
`default_nettype wire
